// ---- verilog/frs_sequencer.sv ----
// fault retry sequencer: output under-voltage fault response with timed
// restarts, delay decode and a wishbone register file
// assumes fault and on/off inputs are pins, asynchronous to mclk
//
// What this block does
// - retry count taken from setting bits 5:3
// - retry zero: stay off until fault cleared
// - retries 1..6, then latch off until cleared
// - retry seven: restart forever until commanded off, bias lost or another fault
// - attempt starts spaced by decoded delay units
// - delay code n decodes to 2^n units
// - delay is grace time or restart interval
// - unit length comes from register 0xc8
// - response 01: run for delay, then retry
// - response 10: shut down now, then retry
// - response 11: off only while fault persists
// - clear, off-on cycle or bias loss clears latch
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "frs_map.svh"

module frs_sequencer (
   input wire logic mclk,
   input wire logic arst_n,
   input wire frs_pkg::frs_wb_req_t wb_req,
   output frs_pkg::frs_wb_rsp_t wb_rsp,
   input wire logic uv_fault,
   input wire logic ctrl_pin_on,
   input wire logic bias_ok,
   input wire logic other_fault,
   output logic out_enable,
   output logic irq
);

   // ==========================================
   // delay decode
   // code n gives 2^n delay units
   function automatic logic [7:0] frs_units(input logic [2:0] code);
      frs_units = 8'h01 << code;
   endfunction

   // ==========================================
   // state
   frs_pkg::frs_state_t r_reg; // registered state
   frs_pkg::frs_state_t r_next; // next state

   // reset image: settings at their defaults, sequencer idle, output off
   localparam frs_pkg::frs_state_t frs_rst_image = '{
      s1: 4'h0,
      s2: 4'h0,
      st: frs_pkg::FRS_IDLE,
      resp: `FRS_RESP_RST,
      unit: `FRS_UNIT_RST,
      op_on: 1'b0,
      presc: 5'h00,
      ucnt: 16'h0000,
      dcnt: 8'h00,
      tries: 3'h0,
      out_en: 1'b0,
      ack: 1'b0,
      dat: 32'h00000000,
      ists: 4'h0,
      imsk: `FRS_IMSK_RST,
      irq: 1'b0
   };

   // decoded view of inputs and settings
   logic fault; // synced under-voltage fault
   logic pin_on; // synced control pin
   logic bias; // synced bias good
   logic oth; // synced other shutdown fault
   logic want_on; // all on-conditions present
   logic [1:0] rsp; // response code
   logic [2:0] rty; // retry setting
   logic [2:0] dly; // delay code
   logic tick; // 1 us step
   logic utick; // one delay unit elapsed
   logic full; // unit tally has reached the decoded delay
   logic done; // decoded delay elapsed
   logic acc; // bus access this cycle
   logic wr; // bus write this cycle
   logic [9:0] idx; // word index
   logic clr; // clear-faults pulse
   logic trst; // restart delay timer
   frs_pkg::frs_st_t shut_to; // target after shutdown
   logic [3:0] ev; // interrupt events
   logic [3:0] w1c; // interrupt clear bits

   // ==========================================
   // input and setting decode
   always_comb begin
      fault = r_reg.s2[0];
      pin_on = r_reg.s2[1];
      bias = r_reg.s2[2];
      oth = r_reg.s2[3];
      want_on = r_reg.op_on & pin_on & bias;
      rsp = r_reg.resp[`FRS_RSP_HI:`FRS_RSP_LO];
      rty = r_reg.resp[`FRS_RTY_HI:`FRS_RTY_LO];
      dly = r_reg.resp[`FRS_DLY_HI:`FRS_DLY_LO];
      // no retries means stay off right away
      shut_to = (rty == `FRS_RTY_NONE) ? frs_pkg::FRS_LATCH : frs_pkg::FRS_BACK;
   end

   // ==========================================
   // delay timer: us prescaler, unit counter, unit tally
   always_comb begin
      tick = (r_reg.presc == 5'(`FRS_CYC_TICK - 1));
      // unit length from the unit register, zero acts as one
      utick = tick && (({1'b0, r_reg.ucnt} + 17'h00001) >= {1'b0, r_reg.unit});
      // delay is a count of decoded units
      full = (r_reg.dcnt >= frs_units(dly));
      // the last unit counts as done on its own tick, so attempt starts are
      // not pushed one cycle late by the registered tally
      done = full || (utick && ((r_reg.dcnt + 8'h01) >= frs_units(dly)));
   end

   // ==========================================
   // bus decode
   always_comb begin
      acc = wb_req.cyc & wb_req.stb & ~r_reg.ack;
      wr = acc & wb_req.we;
      idx = wb_req.adr[11:2];
      clr = wr && (idx == `FRS_IDX_CTRL) && wb_req.sel[0] && wb_req.dat[`FRS_CTRL_CLR];
      w1c = (wr && (idx == `FRS_IDX_ISTS) && wb_req.sel[0]) ? wb_req.dat[3:0] : 4'h0;
   end

   // ==========================================
   // next state
   always_comb begin
      r_next = r_reg;
      trst = 1'b0;
      ev = 4'h0;
      // two-stage synchronisers
      r_next.s1 = {other_fault, bias_ok, ctrl_pin_on, uv_fault};
      r_next.s2 = r_reg.s1;

      // timer advance
      r_next.presc = tick ? 5'h00 : r_reg.presc + 5'h01;
      if (utick) begin
         r_next.ucnt = 16'h0000;
      end else if (tick) begin
         r_next.ucnt = r_reg.ucnt + 16'h0001;
      end
      if (utick && !full) begin
         r_next.dcnt = r_reg.dcnt + 8'h01;
      end

      // single-cycle ack, read data
      r_next.ack = acc;
      if (acc && !wb_req.we) begin
         unique case (idx)
            `FRS_IDX_RESP: r_next.dat = {24'h000000, r_reg.resp};
            `FRS_IDX_UNIT: r_next.dat = {16'h0000, r_reg.unit};
            `FRS_IDX_CTRL: r_next.dat = {31'h00000000, r_reg.op_on};
            `FRS_IDX_STAT: r_next.dat = {24'h000000, r_reg.tries, r_reg.st,
                                         r_reg.out_en, fault};
            `FRS_IDX_ISTS: r_next.dat = {28'h0000000, r_reg.ists};
            `FRS_IDX_IMSK: r_next.dat = {28'h0000000, r_reg.imsk};
            default: r_next.dat = 32'h00000000;
         endcase
      end

      // register writes, byte lane 0 and 1
      if (wr) begin
         if (idx == `FRS_IDX_RESP && wb_req.sel[0]) begin
            r_next.resp = wb_req.dat[7:0];
         end
         if (idx == `FRS_IDX_UNIT) begin
            if (wb_req.sel[0]) begin
               r_next.unit[7:0] = wb_req.dat[7:0];
            end
            if (wb_req.sel[1]) begin
               r_next.unit[15:8] = wb_req.dat[15:8];
            end
         end
         if (idx == `FRS_IDX_CTRL && wb_req.sel[0]) begin
            r_next.op_on = wb_req.dat[`FRS_CTRL_ON];
         end
         if (idx == `FRS_IDX_IMSK && wb_req.sel[0]) begin
            r_next.imsk = wb_req.dat[3:0];
         end
      end

      // sequencer
      if (!want_on) begin
         // commanded off or bias lost: stop and forget
         r_next.st = frs_pkg::FRS_IDLE;
         r_next.tries = 3'h0;
         trst = 1'b1;
      end else if (oth && r_reg.st != frs_pkg::FRS_IDLE) begin
         // another fault forces shutdown, ends endless retry
         r_next.st = frs_pkg::FRS_LATCH;
      end else begin
         unique case (r_reg.st)
            frs_pkg::FRS_IDLE: begin
               // fresh start with clean counters, never into another fault
               if (!oth) begin
                  r_next.st = frs_pkg::FRS_RUN;
               end
               r_next.tries = 3'h0;
               trst = 1'b1;
            end
            frs_pkg::FRS_RUN: begin
               if (fault) begin
                  ev[`FRS_EV_FAULT] = 1'b1;
                  trst = 1'b1;
                  unique case (rsp)
                     `FRS_RSP_IGNORE: r_next.st = frs_pkg::FRS_RUN;
                     `FRS_RSP_GRACE: r_next.st = frs_pkg::FRS_GRACE;
                     `FRS_RSP_SHUT: r_next.st = shut_to;
                     `FRS_RSP_HOLD: r_next.st = frs_pkg::FRS_HOLD;
                  endcase
               end
            end
            frs_pkg::FRS_GRACE: begin
               // keep running for the delay
               if (!fault) begin
                  r_next.st = frs_pkg::FRS_RUN;
               end else if (done) begin
                  r_next.st = shut_to;
                  trst = 1'b1;
               end
            end
            frs_pkg::FRS_HOLD: begin
               // re-enable once the fault is gone
               if (!fault) begin
                  r_next.st = frs_pkg::FRS_RUN;
                  ev[`FRS_EV_GOOD] = 1'b1;
               end
            end
            frs_pkg::FRS_BACK: begin
               // output off, wait for the next attempt start
               if (done) begin
                  if (rty != `FRS_RTY_FOREVER && r_reg.tries == rty) begin
                     r_next.st = frs_pkg::FRS_LATCH;
                  end else begin
                     r_next.st = frs_pkg::FRS_TRY;
                     trst = 1'b1;
                     if (rty != `FRS_RTY_FOREVER) begin
                        r_next.tries = r_reg.tries + 3'h1;
                     end
                  end
               end
            end
            frs_pkg::FRS_TRY: begin
               // attempt fails on a fault, timer keeps spacing starts
               if (fault) begin
                  r_next.st = frs_pkg::FRS_BACK;
                  ev[`FRS_EV_FAULT] = 1'b1;
               end else if (done) begin
                  r_next.st = frs_pkg::FRS_RUN;
                  r_next.tries = 3'h0;
                  ev[`FRS_EV_GOOD] = 1'b1;
               end
            end
            frs_pkg::FRS_LATCH: begin
               // clear-faults reopens the sequence here, as does losing want_on above
               if (clr) begin
                  r_next.st = frs_pkg::FRS_IDLE;
                  r_next.tries = 3'h0;
                  trst = 1'b1;
               end
            end
            default: r_next.st = frs_pkg::FRS_IDLE;
         endcase
      end

      // timer restart
      if (trst) begin
         r_next.presc = 5'h00;
         r_next.ucnt = 16'h0000;
         r_next.dcnt = 8'h00;
      end

      // events from state moves
      if (r_next.st == frs_pkg::FRS_TRY && r_reg.st != frs_pkg::FRS_TRY) begin
         ev[`FRS_EV_RETRY] = 1'b1;
      end
      if (r_next.st == frs_pkg::FRS_LATCH && r_reg.st != frs_pkg::FRS_LATCH) begin
         ev[`FRS_EV_LATCH] = 1'b1;
      end

      // output on in running states, off at once on shutdown
      r_next.out_en = (r_next.st == frs_pkg::FRS_RUN) ||
                      (r_next.st == frs_pkg::FRS_GRACE) ||
                      (r_next.st == frs_pkg::FRS_TRY);

      // sticky events, write one to clear, a new event wins over the clear
      r_next.ists = (r_reg.ists & ~w1c) | ev;
      // level interrupt from unmasked status bits
      r_next.irq = |(r_next.ists & r_next.imsk);
   end

   // ==========================================
   // state register, reset loads constants only
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         r_reg <= frs_rst_image;
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================
   // outputs straight from flip-flops
   assign wb_rsp = '{ack: r_reg.ack, dat: r_reg.dat};
   assign out_enable = r_reg.out_en;
   assign irq = r_reg.irq;

endmodule

// ---- verilog/frs_map.svh ----
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit classic wishbone slave decoding word indices
`ifndef FRS_MAP_SVH
`define FRS_MAP_SVH

// ==========================================
// register word indices (byte address = index * 4)
`define FRS_IDX_CTRL 10'h001
`define FRS_IDX_STAT 10'h002
`define FRS_IDX_ISTS 10'h003
`define FRS_IDX_IMSK 10'h004
`define FRS_IDX_RESP 10'h045
`define FRS_IDX_UNIT 10'h0c8

// ==========================================
// fault response setting fields
`define FRS_RSP_HI 7
`define FRS_RSP_LO 6
`define FRS_RTY_HI 5
`define FRS_RTY_LO 3
`define FRS_DLY_HI 2
`define FRS_DLY_LO 0
`define FRS_RSP_IGNORE 2'h0
`define FRS_RSP_GRACE 2'h1
`define FRS_RSP_SHUT 2'h2
`define FRS_RSP_HOLD 2'h3
`define FRS_RTY_NONE 3'h0
`define FRS_RTY_FOREVER 3'h7

// ==========================================
// control bits and interrupt event bits
`define FRS_CTRL_ON 0
`define FRS_CTRL_CLR 1
`define FRS_EV_FAULT 0
`define FRS_EV_RETRY 1
`define FRS_EV_LATCH 2
`define FRS_EV_GOOD 3

// ==========================================
// reset values
`define FRS_RESP_RST 8'h80
`define FRS_UNIT_RST 16'h0001
`define FRS_IMSK_RST 4'h0

// ==========================================
// timing: one delay unit step is 1 us of mclk
`define FRS_CLK_NS 50
`define FRS_TICK_NS 1000
`define FRS_CYC_TICK (`FRS_TICK_NS / `FRS_CLK_NS)

`endif

// ---- verilog/frs_pkg.sv ----
// types of the fault retry sequencer: bus carriers, states, whole state
// assumes frs_map.svh is on the include path
package frs_pkg;

   // ==========================================
   // wishbone request and answer carriers
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [11:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } frs_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } frs_wb_rsp_t;

   // ==========================================
   // sequencer states
   typedef enum logic [2:0] {
      FRS_IDLE,
      FRS_RUN,
      FRS_GRACE,
      FRS_HOLD,
      FRS_BACK,
      FRS_TRY,
      FRS_LATCH
   } frs_st_t;

   // ==========================================
   // every flip-flop of the block
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      frs_st_t st;
      logic [7:0] resp;
      logic [15:0] unit;
      logic op_on;
      logic [4:0] presc;
      logic [15:0] ucnt;
      logic [7:0] dcnt;
      logic [2:0] tries;
      logic out_en;
      logic ack;
      logic [31:0] dat;
      logic [3:0] ists;
      logic [3:0] imsk;
      logic irq;
   } frs_state_t;

endpackage

// ---- bench/frs_sequencer_props.sv ----
// port checker of the fault retry sequencer
// assumes a bind onto frs_sequencer, seeing its ports only
`timescale 1ns/1ps
module frs_sequencer_props (
   input wire logic mclk,
   input wire logic arst_n,
   input wire frs_pkg::frs_wb_req_t wb_req,
   input wire frs_pkg::frs_wb_rsp_t wb_rsp,
   input wire logic uv_fault,
   input wire logic ctrl_pin_on,
   input wire logic bias_ok,
   input wire logic other_fault,
   input wire logic out_enable,
   input wire logic irq
);
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // ==========================================
   // bus handshake
   a_ack_one_cycle: assert property (wb_rsp.ack |=> !wb_rsp.ack)
      else $error("ack held longer than one cycle");
   a_ack_needs_req: assert property (wb_rsp.ack |-> wb_req.cyc && wb_req.stb)
      else $error("ack without a request");
   a_ack_comes_soon: assert property ($rose(wb_req.stb) |-> ##[0:8] wb_rsp.ack)
      else $error("no ack within eight cycles");
   // ==========================================
   // output enable against pins and faults
   a_pin_off_holds: assert property (!ctrl_pin_on [*6] |-> !out_enable)
      else $error("output on while pin commands off");
   a_bias_off_holds: assert property (!bias_ok [*6] |-> !out_enable)
      else $error("output on without bias");
   a_other_fault_off: assert property (other_fault [*6] |-> !out_enable)
      else $error("output on during another fault");
   a_retry_gap_min: assert property ($fell(out_enable) && uv_fault |=> !out_enable [*8])
      else $error("restart sooner than one delay unit");
   a_rise_enabled: assert property ($rose(out_enable) |->
      $past(ctrl_pin_on, 3) && $past(bias_ok, 3) && !$past(other_fault, 3))
      else $error("output rose while not permitted");
endmodule

// ---- bench/frs_stage_model.sv ----
// power stage model: a load fault and a log of output restarts
// assumes out_enable from the sequencer, fault request from the bench
`timescale 1ns/1ps
module frs_stage_model (
   input wire logic mclk,
   input wire logic out_enable,
   input wire logic short_on,
   output logic uv_fault,
   output int rises,
   output int gap
);
   int now = 0; // cycle count
   int last = 0; // cycle of the latest restart
   int rise_cnt = 0; // restarts seen
   int last_gap = 0; // spacing of the latest two starts
   logic oe_q = 1'b0; // previous enable
   // a shorted load keeps the rail low whether driven or not
   assign uv_fault = short_on;
   assign rises = rise_cnt;
   assign gap = last_gap;
   // ==========================================
   // count restarts and the spacing of their starts
   always @(posedge mclk) begin
      now <= now + 1;
      oe_q <= out_enable;
      if (out_enable && !oe_q) begin
         rise_cnt <= rise_cnt + 1;
         last_gap <= now - last;
         last <= now;
      end
   end
endmodule

// ---- bench/fault_retry_sequencer_test.sv ----
// self-checking bench of the fault retry sequencer
// assumes frs_map.svh on the include path, stage model and checker
`timescale 1ns/1ps
`include "frs_map.svh"
module fault_retry_sequencer_test;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   frs_pkg::frs_wb_req_t wb_req = '0;
   frs_pkg::frs_wb_rsp_t wb_rsp;
   logic ctrl_pin_on = 1'b1;
   logic bias_ok = 1'b1;
   logic other_fault = 1'b0;
   logic short_on = 1'b0;
   logic uv_fault, out_enable, irq;
   int rises, gap, base;
   int bad_count = 0;
   int n_tests = 0;
   int ticks = 0;
   logic [31:0] rd; // last read data
   always #25 mclk = ~mclk;
   frs_sequencer dut (.mclk(mclk), .arst_n(arst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
      .uv_fault(uv_fault), .ctrl_pin_on(ctrl_pin_on), .bias_ok(bias_ok),
      .other_fault(other_fault), .out_enable(out_enable), .irq(irq));
   frs_stage_model stage (.mclk(mclk), .out_enable(out_enable), .short_on(short_on),
      .uv_fault(uv_fault), .rises(rises), .gap(gap));
   // ==========================================
   // shared tasks
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask
   // one classic cycle, held until ack
   task automatic wb(input logic we, input logic [9:0] idx, input logic [31:0] d);
      @(posedge mclk);
      wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:{idx, 2'b00}, sel:4'hf, dat:d};
      do @(posedge mclk); while (wb_rsp.ack !== 1'b1);
      rd = wb_rsp.dat;
      wb_req <= '0;
   endtask
   task automatic setp(input logic [1:0] r, input logic [2:0] t, input logic [2:0] d);
      wb(1'b1, `FRS_IDX_RESP, {24'h0, r, t, d});
   endtask
   task automatic wait_oe(input logic v, input int lim, input string what);
      int n = 0;
      while (out_enable !== v && n < lim) begin
         @(posedge mclk);
         n++;
      end
      chk(what, {31'h0, v}, {31'h0, out_enable});
   endtask
   // fault gone, output off then on again
   task automatic restart_clean();
      short_on <= 1'b0;
      wb(1'b1, `FRS_IDX_CTRL, 32'h0);
      wb(1'b1, `FRS_IDX_CTRL, 32'h1);
      wait_oe(1'b1, 400, "oe after off-on");
   endtask
   // ==========================================
   // scenarios
   task automatic t_regs();
      wb(1'b0, `FRS_IDX_RESP, 32'h0);
      chk("resp reset", {24'h0, `FRS_RESP_RST}, rd);
      wb(1'b0, `FRS_IDX_UNIT, 32'h0);
      chk("unit reset", {16'h0, `FRS_UNIT_RST}, rd);
      wb(1'b0, 10'h3ff, 32'h0);
      wb(1'b1, `FRS_IDX_CTRL, 32'h1);
      wait_oe(1'b1, 400, "oe on");
      $display("test regs done");
   endtask
   task automatic t_retry();
      int per, r;
      for (int i = 0; i < 8; i++) begin
         r = i % 6 + 1;
         per = (1 << i) * `FRS_CYC_TICK;
         setp(`FRS_RSP_SHUT, r[2:0], i[2:0]);
         base = rises;
         short_on <= 1'b1;
         wait_oe(1'b0, 10, "oe shut at fault");
         repeat (per * (r + 2) + 100) @(posedge mclk);
         chk("restart count", r, rises - base);
         if (r > 1) chk("restart spacing", per, gap);
         chk("oe latched off", 32'h0, {31'h0, out_enable});
         restart_clean();
      end
      wb(1'b0, `FRS_IDX_ISTS, 32'h0);
      chk("latch event", 32'h4, rd & 32'h4);
      chk("irq masked", 32'h0, {31'h0, irq});
      wb(1'b1, `FRS_IDX_IMSK, 32'h4);
      repeat (3) @(posedge mclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wb(1'b1, `FRS_IDX_ISTS, 32'h4);
      repeat (3) @(posedge mclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test retry done");
   endtask
   task automatic t_zero();
      setp(`FRS_RSP_SHUT, `FRS_RTY_NONE, 3'h0);
      base = rises;
      short_on <= 1'b1;
      wait_oe(1'b0, 10, "oe shut");
      repeat (300) @(posedge mclk);
      short_on <= 1'b0;
      repeat (100) @(posedge mclk);
      chk("no restart", 32'h0, rises - base);
      chk("oe held off", 32'h0, {31'h0, out_enable});
      wb(1'b1, `FRS_IDX_CTRL, 32'h3);
      wait_oe(1'b1, 400, "oe after clear");
      $display("test zero done");
   endtask
   task automatic t_forever();
      setp(`FRS_RSP_SHUT, `FRS_RTY_FOREVER, 3'h0);
      base = rises;
      short_on <= 1'b1;
      repeat (400) @(posedge mclk);
      chk("endless restarts", 32'h1, {31'h0, (rises - base) > 12});
      ctrl_pin_on <= 1'b0;
      repeat (10) @(posedge mclk);
      base = rises;
      repeat (200) @(posedge mclk);
      chk("stopped by pin", 32'h0, rises - base);
      ctrl_pin_on <= 1'b1;
      restart_clean();
      other_fault <= 1'b1;
      repeat (10) @(posedge mclk);
      chk("oe off other fault", 32'h0, {31'h0, out_enable});
      other_fault <= 1'b0;
      bias_ok <= 1'b0;
      repeat (10) @(posedge mclk);
      chk("oe off no bias", 32'h0, {31'h0, out_enable});
      bias_ok <= 1'b1;
      restart_clean();
      $display("test forever done");
   endtask
   task automatic t_grace();
      int per;
      per = 8 * 3 * `FRS_CYC_TICK;
      wb(1'b1, `FRS_IDX_UNIT, 32'h3);
      wb(1'b0, `FRS_IDX_UNIT, 32'h0);
      chk("unit readback", 32'h3, rd);
      setp(`FRS_RSP_GRACE, `FRS_RTY_NONE, 3'h3);
      short_on <= 1'b1;
      repeat (per - 40) @(posedge mclk);
      chk("oe kept in grace", 32'h1, {31'h0, out_enable});
      wait_oe(1'b0, 80, "oe off after grace");
      wb(1'b1, `FRS_IDX_UNIT, 32'h1);
      restart_clean();
      $display("test grace done");
   endtask
   task automatic t_hold();
      setp(`FRS_RSP_IGNORE, `FRS_RTY_NONE, 3'h0);
      short_on <= 1'b1;
      repeat (100) @(posedge mclk);
      chk("oe kept ignored", 32'h1, {31'h0, out_enable});
      short_on <= 1'b0;
      setp(`FRS_RSP_HOLD, `FRS_RTY_NONE, 3'h0);
      short_on <= 1'b1;
      wait_oe(1'b0, 10, "oe off in fault");
      repeat (200) @(posedge mclk);
      chk("oe off while fault", 32'h0, {31'h0, out_enable});
      short_on <= 1'b0;
      wait_oe(1'b1, 50, "oe back by itself");
      $display("test hold done");
   endtask
   // ==========================================
   // hang guard and main sequence
   always @(posedge mclk) begin
      ticks <= ticks + 1;
      if (ticks == 60000) begin
         bad_count++;
         $display("[FAIL] run length expected under 60000 seen %0d", ticks);
         give_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      t_regs();
      t_retry();
      t_zero();
      t_forever();
      t_grace();
      t_hold();
      give_verdict();
   end
endmodule
bind frs_sequencer frs_sequencer_props props (.mclk(mclk), .arst_n(arst_n),
   .wb_req(wb_req), .wb_rsp(wb_rsp), .uv_fault(uv_fault), .ctrl_pin_on(ctrl_pin_on),
   .bias_ok(bias_ok), .other_fault(other_fault), .out_enable(out_enable), .irq(irq));
